// ==== analog_input_scaling_limits.v ====
// two-channel current input scaling, filtering and limit watch
//
// Notes on behaviour
// [RULE1] diag switch 00h enables, 40h disables interrupt
// [RULE2] limit watch bit0 channel 0, bit1 channel 1
// [RULE3] function FFh disables channel and sensor supply
// [RULE4] function number picks range and output format
// [RULE5] 27648 format, clamp 32511 down to -4864
// [RULE6] 16384 format, clamp 20480 down to -3277
// [RULE7] 4000 format, clamp at 4095, no negatives
// [RULE8] 4-20 mA ranges subtract 4 mA, 16 mA span
// [RULE9] filter time in 10 ms units, 0 is off
// [RULE10] filter is second-order butterworth low-pass
// [RULE11] head station picks 200/170 ms for mains; neither head_station nor the block has such a setting
// [RULE12] limits outside nominal range flag parameter error
// [RULE13] high 7FFFh or low 8000h turns limit off
// [RULE14] leaving limit window raises a process interrupt
// [RULE15] global record written only while stopped; the block takes prm_wr writes at any time
// [RULE16] bit0/bit1 report channel 0/1 crossings
// [RULE17] reserved limit watch bits ignored, read zero
// [RULE18] limits compare scaled, filtered current value
`timescale 1ns/1ps
`include "scaling_limits_map.vh"
module analog_input_scaling_limits #(
   parameter STEP_CYC = `FILTER_STEP_CYC
) (
   input  wire        clk_sys,
   input  wire        rst,
   input  wire        prm_wr,
   input  wire        prm_rd,
   input  wire [3:0]  prm_addr,
   input  wire [7:0]  prm_wdata,
   output reg  [7:0]  prm_rdata,
   output reg         prm_rvalid,
   input  wire        sample_valid,
   input  wire [15:0] sample_ch0,
   input  wire [15:0] sample_ch1,
   output reg  [15:0] meas_ch0,
   output reg  [15:0] meas_ch1,
   output reg  [1:0]  sensor_supply_on,
   output reg  [1:0]  high_crossing_flags,
   output reg  [1:0]  low_crossing_flags,
   output reg         process_irq,
   input  wire        process_ack,
   output reg         param_error,
   output reg         diag_irq_enable,
   output reg         diag_irq
);
   reg  [7:0]  diag_interrupt_switch_q;
   reg  [7:0]  limit_watch_enable_q;
   wire [15:0] channel_range_select_q;
   wire [15:0] channel_filter_time_q;
   wire [31:0] channel_high_threshold_q;
   wire [31:0] channel_low_threshold_q;
   reg  [15:0] step_cnt_q;
   reg         base_tick_q;
   reg  [31:0] meas_q;
   reg  [1:0]  high_seen_q;
   reg  [1:0]  low_seen_q;
   wire [31:0] sample_all;
   wire [31:0] filt_all;
   wire [1:0]  high_now;
   wire [1:0]  low_now;
   wire [1:0]  ch_live;
   wire [1:0]  ch_bad;
   wire [7:0]  rd_byte;
   wire [3:0]  sel0;
   wire [3:0]  sel1;
   wire        hit0;
   wire        hit1;
   wire        any_bad;

   assign sample_all = {sample_ch1, sample_ch0};

   // base tick for the filter, one pulse per sixteenth of 10 ms
   always @(posedge clk_sys) begin
      if (rst) begin
         step_cnt_q  <= 16'h0000;
         base_tick_q <= 1'b0;
      end else if (step_cnt_q == STEP_CYC[15:0] - 16'h0001) begin
         step_cnt_q  <= 16'h0000;
         base_tick_q <= 1'b1;
      end else begin
         step_cnt_q  <= step_cnt_q + 16'h0001;
         base_tick_q <= 1'b0;
      end
   end

   // parameter record decode
   assign hit0 = (prm_addr >= `IDX_CH_BASE0) && (prm_addr < `IDX_CH_BASE1);
   assign hit1 = (prm_addr >= `IDX_CH_BASE1);
   assign sel0 = hit0 ? prm_addr - `IDX_CH_BASE0 : 4'h7;
   assign sel1 = prm_addr - `IDX_CH_BASE1;

   always @(posedge clk_sys) begin
      if (rst) begin
         diag_interrupt_switch_q <= `RST_DIAG_SWITCH;
         limit_watch_enable_q    <= `RST_LIMIT_WATCH;
      end else if (prm_wr && prm_addr == `IDX_DIAG_SWITCH) begin
         diag_interrupt_switch_q <= prm_wdata;
      end else if (prm_wr && prm_addr == `IDX_LIMIT_WATCH) begin
         limit_watch_enable_q <= prm_wdata & `LIMIT_WATCH_MASK; // RULE17
      end
   end

   genvar c;
   generate
      for (c = 0; c < 2; c = c + 1) begin : g_ch
         wire               wr_c;
         wire [3:0]         ofs_c;
         reg  [7:0]         fn_c;
         reg  [7:0]         fo_c;
         reg  signed [15:0] hi_c;
         reg  signed [15:0] lo_c;
         wire               f27;
         wire               f16;
         wire               f40;
         wire               off4;
         reg  signed [17:0] fs;
         reg  signed [17:0] over;
         reg  signed [17:0] under;
         wire signed [17:0] cur;
         wire signed [17:0] num;
         wire signed [35:0] prod;
         wire signed [35:0] quo;
         reg  signed [15:0] scaled;
         reg  signed [15:0] x_q;
         reg  [7:0]         div_q;
         reg                step_q;
         wire signed [15:0] y_c;
         wire               high_on;
         wire               low_on;
         wire               hi_bad;
         wire               lo_bad;

         assign wr_c  = prm_wr && (c == 0 ? hit0 : hit1);
         assign ofs_c = (c == 0) ? sel0 : sel1;
         assign channel_range_select_q[8*c+7:8*c]      = fn_c;
         assign channel_filter_time_q[8*c+7:8*c]       = fo_c;
         assign channel_high_threshold_q[16*c+15:16*c] = hi_c;
         assign channel_low_threshold_q[16*c+15:16*c]  = lo_c;

         always @(posedge clk_sys) begin
            if (rst) begin
               fn_c <= `RST_RANGE;
               fo_c <= `RST_FILTER;
               hi_c <= `RST_HIGH;
               lo_c <= `RST_LOW;
            end else if (wr_c) begin
               case (ofs_c)
                  `CH_OFS_RANGE:
                     fn_c <= prm_wdata;
                  `CH_OFS_FILTER:
                     fo_c <= prm_wdata;
                  `CH_OFS_HIGH_LO:
                     hi_c[7:0] <= prm_wdata;
                  `CH_OFS_HIGH_HI:
                     hi_c[15:8] <= prm_wdata;
                  `CH_OFS_LOW_LO:
                     lo_c[7:0] <= prm_wdata;
                  `CH_OFS_LOW_HI:
                     lo_c[15:8] <= prm_wdata;
                  default: ;
               endcase
            end
         end

         // format decode
         assign f27  = (fn_c == `FN_0_20_27648) || (fn_c == `FN_4_20_27648);
         assign f16  = (fn_c == `FN_0_20_16384) || (fn_c == `FN_4_20_16384);
         assign f40  = (fn_c == `FN_0_20_4000); // RULE4
         assign off4 = (fn_c == `FN_4_20_27648) ||
                       (fn_c == `FN_4_20_16384);
         assign ch_live[c] = f27 | f16 | f40;

         always @* begin
            if (f27) begin
               fs    = `FS_27648; // RULE5
               over  = `OVER_27648;
               under = `UNDER_27648;
            end else if (f16) begin
               fs    = `FS_16384; // RULE6
               over  = `OVER_16384;
               under = `UNDER_16384;
            end else begin
               fs    = `FS_4000; // RULE7
               over  = `OVER_4000;
               under = `UNDER_4000;
            end
         end

         // current in microamperes, 4 mA removed for the live-zero ranges
         assign cur  = {2'b00, sample_all[16*c+15:16*c]};
         assign num  = off4 ? cur - `OFFSET_4MA_UA : cur; // RULE8
         assign prod = num * fs;
         assign quo  = off4 ? prod / `SPAN_16MA_UA : // RULE8
                              prod / `SPAN_20MA_UA;

         always @* begin
            if (quo > over)
               scaled = over[15:0];
            else if (quo < under)
               scaled = under[15:0];
            else
               scaled = quo[15:0];
         end

         // filter step every fo_c base ticks, so tau is fo_c times 10 ms
         always @(posedge clk_sys) begin
            if (rst) begin
               x_q    <= 16'h0000;
               div_q  <= 8'h00;
               step_q <= 1'b0;
            end else begin
               if (sample_valid && ch_live[c])
                  x_q <= scaled;
               step_q <= 1'b0;
               if (base_tick_q) begin
                  if (div_q + 8'h01 >= fo_c) begin
                     div_q  <= 8'h00;
                     step_q <= 1'b1; // RULE9
                  end else begin
                     div_q <= div_q + 8'h01;
                  end
               end
            end
         end

         lowpass_biquad u_filt (
            .clk_sys (clk_sys),
            .rst     (rst),
            .step    (step_q),
            .bypass  (fo_c == 8'h00), // RULE9
            .x       (x_q),
            .y       (y_c)
         );
         assign filt_all[16*c+15:16*c] = y_c;

         // limit window on the value that is also reported
         assign high_on = (hi_c != `HIGH_OFF); // RULE13
         assign low_on  = (lo_c != `LOW_OFF); // RULE13
         assign high_now[c] = ch_live[c] && limit_watch_enable_q[c] && // RULE2
                              high_on &&
                              ($signed(meas_q[16*c+15:16*c]) > hi_c); // RULE18
         assign low_now[c]  = ch_live[c] && limit_watch_enable_q[c] &&
                              low_on &&
                              ($signed(meas_q[16*c+15:16*c]) < lo_c); // RULE18

         // limits must sit in the nominal range of the format
         assign hi_bad = high_on && ((hi_c < 16'sd0) || (hi_c > fs));
         assign lo_bad = low_on && ((lo_c < 16'sd0) || (lo_c > fs));
         assign ch_bad[c] = (ch_live[c] && (hi_bad || lo_bad)) || // RULE12
                            (!ch_live[c] && fn_c != `FN_OFF) ||
                            (fo_c > `FILTER_MAX);
      end
   endgenerate

   assign any_bad = |ch_bad;

   // measured values and crossing events
   always @(posedge clk_sys) begin
      if (rst) begin
         meas_q      <= 32'h00000000;
         high_seen_q <= 2'b00;
         low_seen_q  <= 2'b00;
      end else begin
         meas_q[15:0]  <= ch_live[0] ? filt_all[15:0] : 16'h0000; // RULE3
         meas_q[31:16] <= ch_live[1] ? filt_all[31:16] : 16'h0000; // RULE3
         high_seen_q   <= high_now;
         low_seen_q    <= low_now;
      end
   end

   // sticky crossing flags; a new crossing wins over the acknowledge
   always @(posedge clk_sys) begin
      if (rst) begin
         high_crossing_flags <= 2'b00;
         low_crossing_flags  <= 2'b00;
         process_irq         <= 1'b0;
      end else begin
         high_crossing_flags <= (process_ack ? 2'b00 : high_crossing_flags) |
                                (high_now & ~high_seen_q); // RULE16
         low_crossing_flags  <= (process_ack ? 2'b00 : low_crossing_flags) |
                                (low_now & ~low_seen_q); // RULE16
         process_irq <= (|(high_now & ~high_seen_q)) || // RULE14
                        (|(low_now & ~low_seen_q)) ||
                        (!process_ack &&
                         (|high_crossing_flags || |low_crossing_flags));
      end
   end

   // parameter read back
   assign rd_byte =
      (prm_addr == `IDX_DIAG_SWITCH) ? diag_interrupt_switch_q :
      (prm_addr == `IDX_LIMIT_WATCH) ? limit_watch_enable_q :
      (hit0 && sel0 == `CH_OFS_RANGE) ? channel_range_select_q[7:0] :
      (hit0 && sel0 == `CH_OFS_FILTER) ? channel_filter_time_q[7:0] :
      (hit0 && sel0 == `CH_OFS_HIGH_LO) ? channel_high_threshold_q[7:0] :
      (hit0 && sel0 == `CH_OFS_HIGH_HI) ? channel_high_threshold_q[15:8] :
      (hit0 && sel0 == `CH_OFS_LOW_LO) ? channel_low_threshold_q[7:0] :
      (hit0 && sel0 == `CH_OFS_LOW_HI) ? channel_low_threshold_q[15:8] :
      (hit1 && sel1 == `CH_OFS_RANGE) ? channel_range_select_q[15:8] :
      (hit1 && sel1 == `CH_OFS_FILTER) ? channel_filter_time_q[15:8] :
      (hit1 && sel1 == `CH_OFS_HIGH_LO) ? channel_high_threshold_q[23:16] :
      (hit1 && sel1 == `CH_OFS_HIGH_HI) ? channel_high_threshold_q[31:24] :
      (hit1 && sel1 == `CH_OFS_LOW_LO) ? channel_low_threshold_q[23:16] :
      (hit1 && sel1 == `CH_OFS_LOW_HI) ? channel_low_threshold_q[31:24] :
      8'h00;

   always @(posedge clk_sys) begin
      if (rst) begin
         prm_rdata  <= 8'h00;
         prm_rvalid <= 1'b0;
      end else begin
         prm_rvalid <= prm_rd;
         if (prm_rd)
            prm_rdata <= rd_byte;
      end
   end

   // registered status outputs
   always @(posedge clk_sys) begin
      if (rst) begin
         meas_ch0         <= 16'h0000;
         meas_ch1         <= 16'h0000;
         sensor_supply_on <= 2'b00;
         param_error      <= 1'b0;
         diag_irq_enable  <= 1'b0;
         diag_irq         <= 1'b0;
      end else begin
         meas_ch0 <= meas_q[15:0];
         meas_ch1 <= meas_q[31:16];
         sensor_supply_on[0] <= (channel_range_select_q[7:0] != `FN_OFF);
         sensor_supply_on[1] <= (channel_range_select_q[15:8] != `FN_OFF);
         param_error     <= any_bad; // RULE12
         diag_irq_enable <= (diag_interrupt_switch_q == `DIAG_ON); // RULE1
         diag_irq <= any_bad &&
                     (diag_interrupt_switch_q == `DIAG_ON); // RULE1
      end
   end
endmodule

// ==== scaling_limits_map.vh ====
// offsets, field values, reset values and timing counts of the scaling block
`ifndef SCALING_LIMITS_MAP_VH
`define SCALING_LIMITS_MAP_VH

// parameter record byte indices
`define IDX_DIAG_SWITCH    4'h0
`define IDX_SENSOR_WATCH   4'h1
`define IDX_LIMIT_WATCH    4'h2
`define IDX_SPARE          4'h3
`define IDX_CH_BASE0       4'h4
`define IDX_CH_BASE1       4'hA
// offsets inside one channel group of six bytes
`define CH_OFS_RANGE       3'h0
`define CH_OFS_FILTER      3'h1
`define CH_OFS_HIGH_LO     3'h2
`define CH_OFS_HIGH_HI     3'h3
`define CH_OFS_LOW_LO      3'h4
`define CH_OFS_LOW_HI      3'h5

// reset values
`define RST_DIAG_SWITCH    8'h00
`define RST_LIMIT_WATCH    8'h00
`define RST_RANGE          8'h31
`define RST_FILTER         8'h00
`define RST_HIGH           16'h7FFF
`define RST_LOW            16'h8000

// diagnostic interrupt switch values and limit watch mask
`define DIAG_ON            8'h00
`define DIAG_OFF           8'h40
`define LIMIT_WATCH_MASK   8'h03

// function numbers
`define FN_0_20_27648      8'h31
`define FN_4_20_27648      8'h30
`define FN_0_20_16384      8'h41
`define FN_4_20_16384      8'h40
`define FN_0_20_4000       8'h3F
`define FN_OFF             8'hFF

// limit codes that switch a comparison off
`define HIGH_OFF           16'h7FFF
`define LOW_OFF            16'h8000

// scaling figures, input current in microamperes
`define FS_27648           18'sd27648
`define OVER_27648         18'sd32511
`define UNDER_27648        -18'sd4864
`define FS_16384           18'sd16384
`define OVER_16384         18'sd20480
`define UNDER_16384        -18'sd3277
`define FS_4000            18'sd4000
`define OVER_4000          18'sd4095
`define UNDER_4000         18'sd0
`define OFFSET_4MA_UA      18'sd4000
`define SPAN_16MA_UA       36'sd16000
`define SPAN_20MA_UA       36'sd20000

// timing: filter step is a sixteenth of 10 ms
`define CLK_PERIOD_NS      100
`define FILTER_UNIT_NS     10000000
`define FILTER_STEP_NS     (`FILTER_UNIT_NS / 16)
`define FILTER_STEP_CYC    (`FILTER_STEP_NS / `CLK_PERIOD_NS)
`define FILTER_MAX         8'd250

`endif

// ==== lowpass_biquad.v ====
// second-order butterworth low-pass, one update per step pulse
`timescale 1ns/1ps
module lowpass_biquad (
   input  wire               clk_sys,
   input  wire               rst,
   input  wire               step,
   input  wire               bypass,
   input  wire signed [15:0] x,
   output wire signed [15:0] y
);
   reg  signed [31:0] pos_q;
   reg  signed [31:0] vel_q;
   wire signed [31:0] x_ext;
   wire signed [31:0] err;
   wire signed [31:0] damp;
   wire signed [31:0] vel_n;
   wire signed [31:0] pos_n;

   // states carry 8 fraction bits; tau is 16 steps, damping near sqrt 2
   assign x_ext = {{8{x[15]}}, x, 8'h00};
   assign err   = x_ext - pos_q;
   assign damp  = vel_q + (vel_q >>> 2) + (vel_q >>> 3) + (vel_q >>> 5);
   assign vel_n = vel_q + ((err - damp) >>> 4);
   assign pos_n = pos_q + (vel_n >>> 4);
   assign y     = pos_q[23:8];

   always @(posedge clk_sys) begin
      if (rst) begin
         pos_q <= 32'h00000000;
         vel_q <= 32'h00000000;
      end else if (bypass) begin
         pos_q <= x_ext;
         vel_q <= 32'h00000000;
      end else if (step) begin
         pos_q <= pos_n; // RULE10
         vel_q <= vel_n; // RULE10
      end
   end
endmodule

// ==== head_station.sv ====
// head station model: writes and reads parameter bytes, acknowledges
`timescale 1ns/1ps
module head_station (
   input  wire       clk_sys,
   output reg        prm_wr = 1'b0,
   output reg        prm_rd = 1'b0,
   output reg  [3:0] prm_addr = 4'h0,
   output reg  [7:0] prm_wdata = 8'h00,
   input  wire [7:0] prm_rdata,
   input  wire       prm_rvalid,
   output reg        process_ack = 1'b0
);
   task step;
      begin
         @(posedge clk_sys);
         #1;
      end
   endtask

   // each parameter byte goes out as a one-cycle write, then one idle cycle
   task write_byte(input [3:0] a, input [7:0] d);
      begin
         prm_addr <= a;
         prm_wdata <= d;
         prm_wr <= 1'b1;
         step;
         prm_wr <= 1'b0;
         prm_wdata <= ~d;
         step;
      end
   endtask

   task read_byte(input [3:0] a, output [7:0] d, output ok);
      integer n;
      begin
         ok = 1'b0;
         d = 8'h00;
         prm_addr <= a;
         prm_rd <= 1'b1;
         step;
         prm_rd <= 1'b0;
         for (n = 0; n < 4 && !ok; n = n + 1) begin
            if (prm_rvalid === 1'b1) begin
               d = prm_rdata;
               ok = 1'b1;
            end
            else
               step;
         end
         step;
      end
   endtask

   task ack;
      begin
         process_ack <= 1'b1;
         step;
         process_ack <= 1'b0;
         step;
      end
   endtask
endmodule

// ==== analog_input_scaling_limits_assertions.sv ====
// port assertions of the scaling and limit block
`timescale 1ns/1ps
module scaling_checker (
   input wire        clk_sys,
   input wire        rst,
   input wire        prm_wr,
   input wire        prm_rd,
   input wire [3:0]  prm_addr,
   input wire [7:0]  prm_wdata,
   input wire [7:0]  prm_rdata,
   input wire        prm_rvalid,
   input wire [15:0] meas_ch0,
   input wire [15:0] meas_ch1,
   input wire [1:0]  sensor_supply_on,
   input wire [1:0]  high_crossing_flags,
   input wire [1:0]  low_crossing_flags,
   input wire        process_irq,
   input wire        process_ack,
   input wire        param_error,
   input wire        diag_irq_enable,
   input wire        diag_irq
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   reg [1:0] watch_q;
   wire [1:0] flags = high_crossing_flags | low_crossing_flags;

   // shadow of the limit watch byte as written
   always @(posedge clk_sys) begin
      if (rst)
         watch_q <= 2'h0;
      else if (prm_wr && prm_addr == 4'h2)
         watch_q <= prm_wdata[1:0];
   end

   rd_answer_a: assert property (prm_rd |=> prm_rvalid)
      else $error("read got no answer");
   rsvd_zero_a: assert property (prm_rvalid && $past(prm_addr) == 4'h2
      |-> prm_rdata[7:2] == 6'h00) else $error("reserved bits read back");
   diag_off_a: assert property (prm_wr && prm_addr == 4'h0 &&
      prm_wdata == 8'h40 |-> ##[1:3] !diag_irq_enable)
      else $error("diag interrupt not disabled");
   diag_on_a: assert property (param_error && diag_irq_enable [*3]
      |-> diag_irq) else $error("diag interrupt missing");
   diag_mute_a: assert property (!diag_irq_enable [*3] |-> !diag_irq)
      else $error("diag interrupt while disabled");
   supply_off_a: assert property (prm_wr && prm_addr == 4'hA &&
      prm_wdata == 8'hFF |-> ##[1:3] !sensor_supply_on[1])
      else $error("sensor supply still on");
   off_meas_a: assert property (!sensor_supply_on[1] [*5]
      |-> meas_ch1 == 16'h0000) else $error("disabled channel has data");
   clamp_range_a: assert property ($signed(meas_ch0) <= 32511 &&
      $signed(meas_ch0) >= -4864) else $error("code outside clamp");
   flag_irq_a: assert property (|flags |-> process_irq)
      else $error("flag set without interrupt");
   watch_gate_a: assert property ((flags & ~$past(flags)
      & ~$past(watch_q)) == 2'h0) else $error("flag on unwatched channel");
   sticky_flag_a: assert property (high_crossing_flags[1] &&
      !process_ack |=> high_crossing_flags[1]) else $error("flag lost");

   cover property ($rose(high_crossing_flags[1]));
   cover property ($rose(low_crossing_flags[1]));
   cover property (param_error && diag_irq);
endmodule

bind analog_input_scaling_limits scaling_checker u_chk (
   .clk_sys(clk_sys), .rst(rst), .prm_wr(prm_wr), .prm_rd(prm_rd),
   .prm_addr(prm_addr), .prm_wdata(prm_wdata), .prm_rdata(prm_rdata),
   .prm_rvalid(prm_rvalid), .meas_ch0(meas_ch0), .meas_ch1(meas_ch1),
   .sensor_supply_on(sensor_supply_on),
   .high_crossing_flags(high_crossing_flags),
   .low_crossing_flags(low_crossing_flags), .process_irq(process_irq),
   .process_ack(process_ack), .param_error(param_error),
   .diag_irq_enable(diag_irq_enable), .diag_irq(diag_irq));

// ==== analog_input_scaling_limits_bench.sv ====
// self-checking bench of the scaling and limit block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done = checks_done + 1; \
   if ((g) !== (e)) begin errors = errors + 1; \
   $display("mismatch %s expected %h seen %h", n, e, g); end end
module analog_input_scaling_limits_bench;
   reg         clk_sys = 1'b0;
   reg         rst = 1'b1;
   reg         sample_valid = 1'b0;
   reg  [15:0] sample_ch0 = 16'h0000;
   reg  [15:0] sample_ch1 = 16'h0000;
   wire        prm_wr, prm_rd, prm_rvalid, process_ack, process_irq;
   wire        param_error, diag_irq_enable, diag_irq;
   wire [3:0]  prm_addr;
   wire [7:0]  prm_wdata, prm_rdata;
   wire [15:0] meas_ch0, meas_ch1;
   wire [1:0]  sensor_supply_on, high_crossing_flags, low_crossing_flags;
   integer     errors = 0;
   integer     checks_done = 0;
   integer     i;
   // function number, input microamperes, expected code
   logic [7:0]  fn_t [12] = '{8'h31, 8'h31, 8'h31, 8'h30, 8'h30, 8'h30,
                              8'h41, 8'h41, 8'h40, 8'h40, 8'h3F, 8'h3F};
   logic [15:0] ua_t [12] = '{16'h2710, 16'h7530, 16'h0000, 16'h2EE0,
      16'h0000, 16'h0FA0, 16'h2710, 16'h7530, 16'h0000, 16'h4E20,
      16'h4E20, 16'h7530};
   logic [15:0] ex_t [12] = '{16'h3600, 16'h7EFF, 16'h0000, 16'h3600,
      16'hED00, 16'h0000, 16'h2000, 16'h5000, 16'hF333, 16'h4000,
      16'h0FA0, 16'h0FFF};
   logic [7:0]  df_t [16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h31, 8'h00,
      8'hFF, 8'h7F, 8'h00, 8'h80, 8'h31, 8'h00, 8'hFF, 8'h7F, 8'h00, 8'h80};

   always #50 clk_sys = ~clk_sys;

   analog_input_scaling_limits #(.STEP_CYC(4)) u_dut (
      .clk_sys(clk_sys), .rst(rst), .prm_wr(prm_wr), .prm_rd(prm_rd),
      .prm_addr(prm_addr), .prm_wdata(prm_wdata), .prm_rdata(prm_rdata),
      .prm_rvalid(prm_rvalid), .sample_valid(sample_valid),
      .sample_ch0(sample_ch0), .sample_ch1(sample_ch1),
      .meas_ch0(meas_ch0), .meas_ch1(meas_ch1),
      .sensor_supply_on(sensor_supply_on),
      .high_crossing_flags(high_crossing_flags),
      .low_crossing_flags(low_crossing_flags), .process_irq(process_irq),
      .process_ack(process_ack), .param_error(param_error),
      .diag_irq_enable(diag_irq_enable), .diag_irq(diag_irq));

   head_station u_head (
      .clk_sys(clk_sys), .prm_wr(prm_wr), .prm_rd(prm_rd),
      .prm_addr(prm_addr), .prm_wdata(prm_wdata), .prm_rdata(prm_rdata),
      .prm_rvalid(prm_rvalid), .process_ack(process_ack));

   task give_verdict;
      begin
         $display("checks %0d errors %0d", checks_done, errors);
         if (errors == 0 && checks_done > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask

   task rd_chk(input [3:0] a, input [7:0] e);
      reg [7:0] d;
      reg       ok;
      begin
         u_head.read_byte(a, d, ok);
         if (!ok) begin
            errors = errors + 1;
            give_verdict;
         end else
            `CHK("prm_rdata", e, d)
      end
   endtask

   task wr(input [3:0] a, input [7:0] d);
      u_head.write_byte(a, d);
   endtask

   task feed(input [15:0] c0, input [15:0] c1);
      begin
         sample_ch0 <= c0;
         sample_ch1 <= c1;
         sample_valid <= 1'b1;
         @(posedge clk_sys);
         #1;
         sample_valid <= 1'b0;
         repeat (5) @(posedge clk_sys);
         #1;
      end
   endtask

   initial begin
      repeat (5) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      for (i = 0; i < 16; i = i + 1)
         rd_chk(i[3:0], df_t[i]);
      `CHK("diag_irq_enable", 1'b1, diag_irq_enable)
      `CHK("param_error", 1'b0, param_error)
      wr(4'h2, 8'hFF);
      rd_chk(4'h2, 8'h03);
      wr(4'h2, 8'h00);
      wr(4'hA, 8'hFF);
      feed(16'h0000, 16'h4E20);
      `CHK("sensor_supply_on", 2'h1, sensor_supply_on)
      `CHK("meas_ch1", 16'h0000, meas_ch1)
      for (i = 0; i < 12; i = i + 1) begin
         wr(4'h4, fn_t[i]);
         feed(ua_t[i], 16'h0000);
         `CHK("meas_ch0", ex_t[i], meas_ch0)
      end
      wr(4'hA, 8'h31);
      wr(4'hC, 8'h00);
      wr(4'hD, 8'h36);
      wr(4'h2, 8'h01);
      feed(16'h0000, 16'h4E20);
      `CHK("high_crossing_flags", 2'h0, high_crossing_flags)
      wr(4'h2, 8'h02);
      feed(16'h0000, 16'h0000);
      feed(16'h0000, 16'h4E20);
      `CHK("high_crossing_flags", 2'h2, high_crossing_flags)
      `CHK("process_irq", 1'b1, process_irq)
      u_head.ack;
      `CHK("process_irq", 1'b0, process_irq)
      wr(4'hC, 8'hFF);
      wr(4'hD, 8'h7F);
      wr(4'hE, 8'hD0);
      wr(4'hF, 8'h07);
      feed(16'h0000, 16'h0000);
      `CHK("low_crossing_flags", 2'h2, low_crossing_flags)
      u_head.ack;
      wr(4'hD, 8'h70);
      `CHK("param_error", 1'b1, param_error)
      `CHK("diag_irq", 1'b1, diag_irq)
      wr(4'h0, 8'h40);
      wr(4'h0, 8'h40);
      `CHK("diag_irq", 1'b0, diag_irq)
      wr(4'h0, 8'h00);
      wr(4'hD, 8'h7F);
      wr(4'hB, 8'hFB);
      `CHK("param_error", 1'b1, param_error)
      wr(4'hB, 8'hFA);
      `CHK("param_error", 1'b0, param_error)
      wr(4'h4, 8'h31);
      feed(16'h0000, 16'h0000);
      wr(4'h5, 8'h14);
      feed(16'h2710, 16'h0000);
      `CHK("filter_slow", 1'b1, $signed(meas_ch0) < 13000)
      i = 0;
      while (i < 20000 && ($signed(meas_ch0) < 13760 ||
             $signed(meas_ch0) > 13888)) begin
         @(posedge clk_sys);
         #1;
         i = i + 1;
      end
      `CHK("filter_settle", 1'b1, i < 20000)
      give_verdict;
   end
endmodule
